/* core/vpsb_defs.svh */
// constants of the voltage protection and status bank: limits, codes, bit positions
// assumes it is included by bare name from the package and the checker
// What this block does
// - hold negative limit, up to 1% over rated
// - hold positive limit, up to 1% over rated
// - queries return negative and positive limits separately
// - combined ceiling write sets both ceilings
// - ceiling query returns positive then negative
// - separate negative ceiling, stored and readable
// - separate positive ceiling, stored and readable
// - pending trigger voltage moves on trigger only
// - over model maximum posts error -222
// - over soft limit stores the limit instead
// - operation condition follows live state, unlatched
// - bit 8 const voltage, 10 const current
// - list, sample, transient and trigger wait bits
// - operation summary is OR of enabled events
// - operation mask written and read back unchanged
// - operation events latch, read returns and clears
// - preset loads masks 8193 and 255
// - questionable events latch bits 13, 12 only
// - questionable bits 0, 1 follow live conditions
// - questionable bits 14, 13, 12 meanings
// - questionable bits 6, 3, 1, 0 meanings
// - questionable summary is OR of enabled events
`ifndef VPSB_DEFS_SVH
`define VPSB_DEFS_SVH

// ----------------------------------------------------------------
// voltage scale, in output code units
// ----------------------------------------------------------------
`define VPSB_RATED_V 16'h2710
`define VPSB_PROT_MAX_V 16'h2774
`define VPSB_ERR_DATA_RANGE 16'hff22

// ----------------------------------------------------------------
// status bits and preset values
// ----------------------------------------------------------------
`define VPSB_OPER_USED 16'h5f60
`define VPSB_OPER_BIT_CV 8
`define VPSB_OPER_BIT_CC 10
`define VPSB_QUES_USED 16'h704b
`define VPSB_QUES_LATCH 16'h3000
`define VPSB_PRESET_OPER_MASK 16'h2001
`define VPSB_PRESET_QUES_MASK 16'h00ff
`define VPSB_SB_BIT_OPER 7
`define VPSB_SB_BIT_QUES 3

`endif

/* core/vpsb_pkg.sv */
// types of the voltage protection and status bank
// assumes the defs header is on the include path
package vpsb_pkg;
`include "vpsb_defs.svh"

    // ----------------------------------------------------------------
    // decoded host commands and queries
    // ----------------------------------------------------------------
    typedef enum logic [4:0] {
        VPSB_CMD_PROT_NEG, VPSB_CMD_PROT_NEG_Q, VPSB_CMD_PROT_POS, VPSB_CMD_PROT_POS_Q,
        VPSB_CMD_PROT_BOTH, VPSB_CMD_CEIL_BOTH, VPSB_CMD_CEIL_BOTH_Q,
        VPSB_CMD_CEIL_NEG, VPSB_CMD_CEIL_NEG_Q, VPSB_CMD_CEIL_POS, VPSB_CMD_CEIL_POS_Q,
        VPSB_CMD_TRIG_VOLT, VPSB_CMD_TRIG_VOLT_Q, VPSB_CMD_TRIGGER,
        VPSB_CMD_OPER_COND_Q, VPSB_CMD_OPER_EVENT_Q, VPSB_CMD_OPER_MASK, VPSB_CMD_OPER_MASK_Q,
        VPSB_CMD_QUES_COND_Q, VPSB_CMD_QUES_EVENT_Q, VPSB_CMD_QUES_MASK, VPSB_CMD_QUES_MASK_Q,
        VPSB_CMD_PRESET
    } vpsb_cmd_t;

    // ----------------------------------------------------------------
    // whole state of the bank
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [15:0] prot_neg;
        logic [15:0] prot_pos;
        logic [15:0] ceil_neg;
        logic [15:0] ceil_pos;
        logic [15:0] trig_pending;
        logic [15:0] setpoint;
        logic [15:0] oper_sync1;
        logic [15:0] oper_cond;
        logic [15:0] oper_prev;
        logic [15:0] oper_event;
        logic [15:0] oper_mask;
        logic [15:0] ques_sync1;
        logic [15:0] ques_cond;
        logic [15:0] ques_prev;
        logic [15:0] ques_event;
        logic [15:0] ques_mask;
        logic oper_summary;
        logic ques_summary;
        logic rsp_valid;
        logic [15:0] rsp_data;
        logic [15:0] rsp_data2;
        logic err_valid;
        logic [15:0] err_code;
    } vpsb_state_t;
endpackage

/* core/vpsb_bank.sv */
// voltage protection limits, ceilings, trigger level and status groups
// assumes commands arrive already parsed, one per cycle, from the host front end;
// condition inputs come from the analog side and are treated as asynchronous
`timescale 1ns/1ps

module vpsb_bank
    import vpsb_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire vpsb_cmd_t cmd_code,
    input wire logic [15:0] cmd_data,
    input wire logic [15:0] upper_soft_voltage_limit,
    input wire logic const_voltage_flag,
    input wire logic const_current_flag,
    input wire logic list_done_flag,
    input wire logic list_active_flag,
    input wire logic sample_done_flag,
    input wire logic transient_done_flag,
    input wire logic transient_primed_flag,
    input wire logic trigger_wait_flag,
    input wire logic absorbing_energy_flag,
    input wire logic current_fault_flag,
    input wire logic voltage_fault_flag,
    input wire logic follower_fault_flag,
    input wire logic thermal_fault_flag,
    input wire logic current_regulation_fault,
    input wire logic voltage_regulation_fault,
    output logic rsp_valid,
    output logic [15:0] rsp_data,
    output logic [15:0] rsp_data2,
    output logic err_valid,
    output logic [15:0] err_code,
    output logic [15:0] prot_neg_limit,
    output logic [15:0] prot_pos_limit,
    output logic [15:0] voltage_setpoint,
    output logic oper_summary,
    output logic ques_summary
);

    // ----------------------------------------------------------------
    // state and live condition vectors
    // ----------------------------------------------------------------
    vpsb_state_t s_q;
    vpsb_state_t s_d;
    logic [15:0] oper_raw;
    logic [15:0] ques_raw;
    logic [15:0] oper_rise;
    logic [15:0] ques_rise;

    // operation condition bits gathered at their positions
    always_comb begin
        oper_raw = 16'h0000;
        oper_raw[`VPSB_OPER_BIT_CV] = const_voltage_flag;
        oper_raw[`VPSB_OPER_BIT_CC] = const_current_flag;
        oper_raw[14] = list_active_flag;
        oper_raw[12] = list_done_flag;
        oper_raw[11] = sample_done_flag;
        oper_raw[9] = transient_done_flag;
        oper_raw[6] = transient_primed_flag;
        oper_raw[5] = trigger_wait_flag;
    end

    // questionable condition bits gathered at their positions
    always_comb begin
        ques_raw = 16'h0000;
        ques_raw[14] = absorbing_energy_flag;
        ques_raw[13] = current_fault_flag;
        ques_raw[12] = voltage_fault_flag;
        ques_raw[6] = follower_fault_flag;
        ques_raw[3] = thermal_fault_flag;
        ques_raw[1] = current_regulation_fault;
        ques_raw[0] = voltage_regulation_fault;
    end

    // rising edges seen on the synchronised copies only
    assign oper_rise = s_q.oper_cond & ~s_q.oper_prev;
    assign ques_rise = s_q.ques_cond & ~s_q.ques_prev & `VPSB_QUES_LATCH;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // smaller of two magnitudes, used to keep a limit under its ceiling
    function automatic logic [15:0] vpsb_min(input logic [15:0] a, input logic [15:0] b);
        vpsb_min = (a < b) ? a : b;
    endfunction

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    // one pass per cycle: sync, latch events, then apply the command
    always_comb begin
        s_d = s_q;
        s_d.rsp_valid = 1'b0;
        s_d.err_valid = 1'b0;

        // two-stage sync; stage one feeds only stage two
        s_d.oper_sync1 = oper_raw & `VPSB_OPER_USED;
        s_d.oper_cond = s_q.oper_sync1;
        s_d.oper_prev = s_q.oper_cond;
        s_d.ques_sync1 = ques_raw & `VPSB_QUES_USED;
        s_d.ques_cond = s_q.ques_sync1;
        s_d.ques_prev = s_q.ques_cond;

        // new events latch every cycle; a read below clears all but an edge arriving now
        s_d.oper_event = s_q.oper_event | oper_rise;
        s_d.ques_event = s_q.ques_event | ques_rise;

        if (cmd_valid) begin
            unique case (cmd_code)
                // protection limits, kept under their ceilings
                VPSB_CMD_PROT_NEG: begin
                    if (cmd_data > `VPSB_PROT_MAX_V) begin
                        s_d.err_valid = 1'b1;
                        s_d.err_code = `VPSB_ERR_DATA_RANGE;
                    end else begin
                        s_d.prot_neg = vpsb_min(cmd_data, s_q.ceil_neg);
                    end
                end
                VPSB_CMD_PROT_POS: begin
                    if (cmd_data > `VPSB_PROT_MAX_V) begin
                        s_d.err_valid = 1'b1;
                        s_d.err_code = `VPSB_ERR_DATA_RANGE;
                    end else begin
                        s_d.prot_pos = vpsb_min(cmd_data, s_q.ceil_pos);
                    end
                end
                VPSB_CMD_PROT_BOTH: begin
                    if (cmd_data > `VPSB_PROT_MAX_V) begin
                        s_d.err_valid = 1'b1;
                        s_d.err_code = `VPSB_ERR_DATA_RANGE;
                    end else begin
                        // asymmetric ceilings reduce each side on its own
                        s_d.prot_neg = vpsb_min(cmd_data, s_q.ceil_neg);
                        s_d.prot_pos = vpsb_min(cmd_data, s_q.ceil_pos);
                    end
                end
                VPSB_CMD_PROT_NEG_Q: begin
                    s_d.rsp_valid = 1'b1;
                    s_d.rsp_data = s_q.prot_neg;
                    s_d.rsp_data2 = 16'h0000;
                end
                VPSB_CMD_PROT_POS_Q: begin
                    s_d.rsp_valid = 1'b1;
                    s_d.rsp_data = s_q.prot_pos;
                    s_d.rsp_data2 = 16'h0000;
                end

                // ceilings; a lowered ceiling pulls its limit down with it
                VPSB_CMD_CEIL_BOTH: begin
                    if (cmd_data > `VPSB_PROT_MAX_V) begin
                        s_d.err_valid = 1'b1;
                        s_d.err_code = `VPSB_ERR_DATA_RANGE;
                    end else begin
                        s_d.ceil_neg = cmd_data;
                        s_d.ceil_pos = cmd_data;
                        s_d.prot_neg = vpsb_min(s_q.prot_neg, cmd_data);
                        s_d.prot_pos = vpsb_min(s_q.prot_pos, cmd_data);
                    end
                end
                VPSB_CMD_CEIL_NEG: begin
                    if (cmd_data > `VPSB_PROT_MAX_V) begin
                        s_d.err_valid = 1'b1;
                        s_d.err_code = `VPSB_ERR_DATA_RANGE;
                    end else begin
                        s_d.ceil_neg = cmd_data;
                        s_d.prot_neg = vpsb_min(s_q.prot_neg, cmd_data);
                    end
                end
                VPSB_CMD_CEIL_POS: begin
                    if (cmd_data > `VPSB_PROT_MAX_V) begin
                        s_d.err_valid = 1'b1;
                        s_d.err_code = `VPSB_ERR_DATA_RANGE;
                    end else begin
                        s_d.ceil_pos = cmd_data;
                        s_d.prot_pos = vpsb_min(s_q.prot_pos, cmd_data);
                    end
                end
                VPSB_CMD_CEIL_BOTH_Q: begin
                    s_d.rsp_valid = 1'b1;
                    s_d.rsp_data = s_q.ceil_pos;
                    s_d.rsp_data2 = s_q.ceil_neg;
                end
                VPSB_CMD_CEIL_NEG_Q: begin
                    s_d.rsp_valid = 1'b1;
                    s_d.rsp_data = s_q.ceil_neg;
                    s_d.rsp_data2 = 16'h0000;
                end
                VPSB_CMD_CEIL_POS_Q: begin
                    s_d.rsp_valid = 1'b1;
                    s_d.rsp_data = s_q.ceil_pos;
                    s_d.rsp_data2 = 16'h0000;
                end

                // trigger level: range error first, then soft clamp
                VPSB_CMD_TRIG_VOLT: begin
                    if (cmd_data > `VPSB_RATED_V) begin
                        s_d.err_valid = 1'b1;
                        s_d.err_code = `VPSB_ERR_DATA_RANGE;
                    end else if (cmd_data > upper_soft_voltage_limit) begin
                        s_d.trig_pending = upper_soft_voltage_limit;
                    end else begin
                        s_d.trig_pending = cmd_data;
                    end
                end
                VPSB_CMD_TRIG_VOLT_Q: begin
                    s_d.rsp_valid = 1'b1;
                    s_d.rsp_data = s_q.trig_pending;
                    s_d.rsp_data2 = 16'h0000;
                end
                VPSB_CMD_TRIGGER: begin
                    s_d.setpoint = s_q.trig_pending;
                end

                // operation group
                VPSB_CMD_OPER_COND_Q: begin
                    s_d.rsp_valid = 1'b1;
                    s_d.rsp_data = s_q.oper_cond;
                    s_d.rsp_data2 = 16'h0000;
                end
                VPSB_CMD_OPER_EVENT_Q: begin
                    s_d.rsp_valid = 1'b1;
                    s_d.rsp_data = s_q.oper_event;
                    s_d.rsp_data2 = 16'h0000;
                    // clear, but an edge arriving now survives
                    s_d.oper_event = oper_rise;
                end
                VPSB_CMD_OPER_MASK: begin
                    s_d.oper_mask = cmd_data;
                end
                VPSB_CMD_OPER_MASK_Q: begin
                    s_d.rsp_valid = 1'b1;
                    s_d.rsp_data = s_q.oper_mask;
                    s_d.rsp_data2 = 16'h0000;
                end

                // questionable group
                VPSB_CMD_QUES_COND_Q: begin
                    s_d.rsp_valid = 1'b1;
                    s_d.rsp_data = s_q.ques_cond;
                    s_d.rsp_data2 = 16'h0000;
                end
                VPSB_CMD_QUES_EVENT_Q: begin
                    s_d.rsp_valid = 1'b1;
                    s_d.rsp_data = s_q.ques_event;
                    s_d.rsp_data2 = 16'h0000;
                    s_d.ques_event = ques_rise;
                end
                VPSB_CMD_QUES_MASK: begin
                    s_d.ques_mask = cmd_data;
                end
                VPSB_CMD_QUES_MASK_Q: begin
                    s_d.rsp_valid = 1'b1;
                    s_d.rsp_data = s_q.ques_mask;
                    s_d.rsp_data2 = 16'h0000;
                end

                // preset: fixed masks, operation events dropped
                VPSB_CMD_PRESET: begin
                    s_d.oper_mask = `VPSB_PRESET_OPER_MASK;
                    s_d.ques_mask = `VPSB_PRESET_QUES_MASK;
                    s_d.oper_event = oper_rise;
                end
                default: begin
                    s_d.rsp_valid = 1'b0;
                end
            endcase
        end

        // summaries follow the registered events and masks
        s_d.oper_summary = |(s_d.oper_event & s_d.oper_mask);
        s_d.ques_summary = |(s_d.ques_event & s_d.ques_mask);
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    // limits and ceilings start at the top of the range; a power-up
    // value saved by the host is not modelled here
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.prot_neg <= `VPSB_PROT_MAX_V;
            s_q.prot_pos <= `VPSB_PROT_MAX_V;
            s_q.ceil_neg <= `VPSB_PROT_MAX_V;
            s_q.ceil_pos <= `VPSB_PROT_MAX_V;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs, all straight from the state register
    // ----------------------------------------------------------------
    assign rsp_valid = s_q.rsp_valid;
    assign rsp_data = s_q.rsp_data;
    assign rsp_data2 = s_q.rsp_data2;
    assign err_valid = s_q.err_valid;
    assign err_code = s_q.err_code;
    assign prot_neg_limit = s_q.prot_neg;
    assign prot_pos_limit = s_q.prot_pos;
    assign voltage_setpoint = s_q.setpoint;
    assign oper_summary = s_q.oper_summary;
    assign ques_summary = s_q.ques_summary;

endmodule

/* verification/vpsb_bank_properties.sv */
// checker of the bank: answer pulses, limit caps, refusals and trigger transfer
// assumes it is bound onto vpsb_bank and sees only that module's ports
`timescale 1ns/1ps
`include "vpsb_defs.svh"
module vpsb_bank_properties
    import vpsb_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire vpsb_cmd_t cmd_code,
    input wire logic [15:0] cmd_data,
    input wire logic [15:0] upper_soft_voltage_limit,
    input wire logic rsp_valid,
    input wire logic [15:0] rsp_data,
    input wire logic [15:0] rsp_data2,
    input wire logic err_valid,
    input wire logic [15:0] err_code,
    input wire logic [15:0] prot_neg_limit,
    input wire logic [15:0] prot_pos_limit,
    input wire logic [15:0] voltage_setpoint
);
    // one clock domain, so clock and reset are given once
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    // ----------------------------------------------------------------
    // answers
    // ----------------------------------------------------------------
    a_idle_no_pulse: assert property (
        !cmd_valid |=> !rsp_valid && !err_valid) else $error("pulse without a command");
    a_limit_query: assert property (
        cmd_valid && (cmd_code == VPSB_CMD_PROT_NEG_Q || cmd_code == VPSB_CMD_PROT_POS_Q)
        |=> rsp_valid && !err_valid) else $error("limit query not answered");
    a_ceil_pair: assert property (
        cmd_valid && cmd_code == VPSB_CMD_CEIL_BOTH_Q |=> rsp_valid
        && rsp_data <= `VPSB_PROT_MAX_V && rsp_data2 <= `VPSB_PROT_MAX_V)
        else $error("ceiling pair missing or above cap");

    // ----------------------------------------------------------------
    // limits and refusals
    // ----------------------------------------------------------------
    a_neg_cap: assert property (
        prot_neg_limit <= `VPSB_PROT_MAX_V) else $error("negative limit above cap");
    a_pos_refuse: assert property (
        cmd_valid && cmd_code == VPSB_CMD_PROT_POS && cmd_data > `VPSB_PROT_MAX_V
        |=> err_valid && err_code == `VPSB_ERR_DATA_RANGE && $stable(prot_pos_limit))
        else $error("oversize positive limit accepted");
    a_trig_range: assert property (
        cmd_valid && cmd_code == VPSB_CMD_TRIG_VOLT && cmd_data > `VPSB_RATED_V
        |=> err_valid && err_code == `VPSB_ERR_DATA_RANGE) else $error("no range error");
    a_soft_clamp: assert property (
        cmd_valid && cmd_code == VPSB_CMD_TRIG_VOLT && cmd_data <= `VPSB_RATED_V
        && cmd_data > upper_soft_voltage_limit |=> !err_valid) else $error("clamp raised error");

    // ----------------------------------------------------------------
    // trigger transfer
    // ----------------------------------------------------------------
    a_trig_hold: assert property (
        !(cmd_valid && cmd_code == VPSB_CMD_TRIGGER) |=> $stable(voltage_setpoint))
        else $error("setpoint moved without trigger");
    a_trig_move: assert property (
        cmd_valid && cmd_code == VPSB_CMD_TRIG_VOLT && cmd_data <= `VPSB_RATED_V
        && cmd_data <= upper_soft_voltage_limit ##1 cmd_valid && cmd_code == VPSB_CMD_TRIGGER
        |=> voltage_setpoint == $past(cmd_data, 2)) else $error("trigger did not transfer");
endmodule

/* verification/vpsb_host_model.sv */
// host controller model: issues decoded commands, one per falling edge
// assumes the bench calls send and quiet only after reset is released
`timescale 1ns/1ps
module vpsb_host_model
    import vpsb_pkg::*;
(
    input wire logic clock,
    output logic cmd_valid,
    output vpsb_cmd_t cmd_code,
    output logic [15:0] cmd_data
);
    // ----------------------------------------------------------------
    // request driving
    // ----------------------------------------------------------------
    // idle at time zero
    initial begin
        cmd_valid = 1'b0;
        cmd_code = VPSB_CMD_PRESET;
        cmd_data = 16'h0000;
    end
    // held over the next rising edge, where the bank takes it
    task automatic send(input vpsb_cmd_t c, input logic [15:0] d);
        @(negedge clock);
        cmd_valid = 1'b1;
        cmd_code = c;
        cmd_data = d;
    endtask
    // released data flips so a stale value never passes for a fresh one
    task automatic quiet();
        @(negedge clock);
        cmd_valid = 1'b0;
        cmd_data = ~cmd_data;
    endtask
    // ceilings stay volatile here; saving them is the host's own step
endmodule

/* verification/tb_top.sv */
// self-checking bench of the voltage protection and status bank
// assumes the package, defs header, host model and checker are compiled first
`timescale 1ns/1ps
module tb_top;
    import vpsb_pkg::*;
    typedef struct {vpsb_cmd_t c; logic [15:0] d; logic rv; logic [15:0] r1;
        logic [15:0] r2; logic ev;} vpsb_row_t;
    logic clock, rst_n, cmd_valid;
    vpsb_cmd_t cmd_code;
    logic [15:0] cmd_data, soft_lim;
    logic [7:0] op_f;
    logic [6:0] q_f;
    logic rsp_valid, err_valid, oper_summary, ques_summary;
    logic [15:0] rsp_data, rsp_data2, err_code, prot_neg_limit, prot_pos_limit;
    logic [15:0] voltage_setpoint;
    int error_cnt = 0;
    int cmp_count = 0;
    logic [15:0] opb [8] = '{16'h0100, 16'h0400, 16'h1000, 16'h4000, 16'h0800, 16'h0200,
        16'h0040, 16'h0020};
    logic [15:0] qb [8] = '{16'h4000, 16'h2000, 16'h1000, 16'h0040, 16'h0008, 16'h0002,
        16'h0001, 16'h0000};
    // ----------------------------------------------------------------
    // ordinary cases: command, data, answer expected, error expected
    // ----------------------------------------------------------------
    vpsb_row_t rows [26] = '{
        '{VPSB_CMD_CEIL_BOTH_Q, 16'h0, 1'b1, 16'h2774, 16'h2774, 1'b0},
        '{VPSB_CMD_CEIL_POS, 16'h2700, 1'b0, 16'h0, 16'h0, 1'b0},
        '{VPSB_CMD_CEIL_POS_Q, 16'h0, 1'b1, 16'h2700, 16'h0, 1'b0},
        '{VPSB_CMD_CEIL_NEG, 16'h2600, 1'b0, 16'h0, 16'h0, 1'b0},
        '{VPSB_CMD_CEIL_NEG_Q, 16'h0, 1'b1, 16'h2600, 16'h0, 1'b0},
        '{VPSB_CMD_PROT_POS, 16'h1000, 1'b0, 16'h0, 16'h0, 1'b0},
        '{VPSB_CMD_PROT_POS_Q, 16'h0, 1'b1, 16'h1000, 16'h0, 1'b0},
        '{VPSB_CMD_PROT_NEG, 16'h2000, 1'b0, 16'h0, 16'h0, 1'b0},
        '{VPSB_CMD_PROT_NEG_Q, 16'h0, 1'b1, 16'h2000, 16'h0, 1'b0},
        '{VPSB_CMD_PROT_NEG, 16'h2775, 1'b0, 16'h0, 16'h0, 1'b1},
        '{VPSB_CMD_PROT_NEG_Q, 16'h0, 1'b1, 16'h2000, 16'h0, 1'b0},
        '{VPSB_CMD_CEIL_BOTH, 16'h2500, 1'b0, 16'h0, 16'h0, 1'b0},
        '{VPSB_CMD_CEIL_BOTH_Q, 16'h0, 1'b1, 16'h2500, 16'h2500, 1'b0},
        '{VPSB_CMD_OPER_MASK, 16'h0500, 1'b0, 16'h0, 16'h0, 1'b0},
        '{VPSB_CMD_OPER_MASK_Q, 16'h0, 1'b1, 16'h0500, 16'h0, 1'b0},
        '{VPSB_CMD_QUES_MASK, 16'hffff, 1'b0, 16'h0, 16'h0, 1'b0},
        '{VPSB_CMD_QUES_MASK_Q, 16'h0, 1'b1, 16'hffff, 16'h0, 1'b0},
        '{VPSB_CMD_TRIG_VOLT, 16'h2711, 1'b0, 16'h0, 16'h0, 1'b1},
        '{VPSB_CMD_TRIG_VOLT, 16'h0800, 1'b0, 16'h0, 16'h0, 1'b0},
        '{VPSB_CMD_TRIG_VOLT_Q, 16'h0, 1'b1, 16'h0800, 16'h0, 1'b0},
        '{VPSB_CMD_TRIGGER, 16'h0, 1'b0, 16'h0, 16'h0, 1'b0},
        '{VPSB_CMD_TRIG_VOLT, 16'h2100, 1'b0, 16'h0, 16'h0, 1'b0},
        '{VPSB_CMD_TRIG_VOLT_Q, 16'h0, 1'b1, 16'h2000, 16'h0, 1'b0},
        '{VPSB_CMD_PRESET, 16'h0, 1'b0, 16'h0, 16'h0, 1'b0},
        '{VPSB_CMD_OPER_MASK_Q, 16'h0, 1'b1, 16'h2001, 16'h0, 1'b0},
        '{VPSB_CMD_QUES_MASK_Q, 16'h0, 1'b1, 16'h00ff, 16'h0, 1'b0}};

    vpsb_host_model i_host (.clock(clock), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_data(cmd_data));
    vpsb_bank i_dut (.clock(clock), .rst_n(rst_n), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cmd_data(cmd_data), .upper_soft_voltage_limit(soft_lim),
        .const_voltage_flag(op_f[0]), .const_current_flag(op_f[1]),
        .list_done_flag(op_f[2]), .list_active_flag(op_f[3]), .sample_done_flag(op_f[4]),
        .transient_done_flag(op_f[5]), .transient_primed_flag(op_f[6]),
        .trigger_wait_flag(op_f[7]), .absorbing_energy_flag(q_f[0]),
        .current_fault_flag(q_f[1]), .voltage_fault_flag(q_f[2]),
        .follower_fault_flag(q_f[3]), .thermal_fault_flag(q_f[4]),
        .current_regulation_fault(q_f[5]), .voltage_regulation_fault(q_f[6]),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_data2(rsp_data2),
        .err_valid(err_valid), .err_code(err_code), .prot_neg_limit(prot_neg_limit),
        .prot_pos_limit(prot_pos_limit), .voltage_setpoint(voltage_setpoint),
        .oper_summary(oper_summary), .ques_summary(ques_summary));

    // ----------------------------------------------------------------
    // clock, compares, verdict
    // ----------------------------------------------------------------
    // 50 MHz
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // one command; the one-cycle answer pulse is checked at the falling edge it stands over
    task automatic do_cmd(input vpsb_cmd_t c, input logic [15:0] d, input logic rv,
        input logic [15:0] r1, input logic [15:0] r2, input logic ev);
        i_host.send(c, d);
        i_host.quiet();
        chk1(rsp_valid, rv);
        chk1(err_valid, ev);
        if (rv) begin
            chk16(rsp_data, r1);
            chk16(rsp_data2, r2);
        end
        if (ev) chk16(err_code, 16'hff22);
    endtask
    // whole run is well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clock);
        error_cnt++;
        close_out();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        op_f = 8'h00;
        q_f = 7'h00;
        soft_lim = 16'h2000;
        repeat (3) @(negedge clock);
        chk16(prot_pos_limit, 16'h2774);
        chk16(prot_neg_limit, 16'h2774);
        repeat (3) @(negedge clock);
        rst_n = 1'b1;
        foreach (rows[i]) begin
            do_cmd(rows[i].c, rows[i].d, rows[i].rv, rows[i].r1, rows[i].r2, rows[i].ev);
        end
        chk16(voltage_setpoint, 16'h0800);
        do_cmd(VPSB_CMD_OPER_MASK, 16'h0100, 1'b0, 16'h0, 16'h0, 1'b0);
        do_cmd(VPSB_CMD_QUES_MASK, 16'h1000, 1'b0, 16'h0, 16'h0, 1'b0);
        // one live condition at a time, so each bit position is seen alone
        for (int i = 0; i < 8; i++) begin
            op_f = 8'(8'h01 << i);
            q_f = 7'(7'h01 << i);
            repeat (4) @(negedge clock);
            do_cmd(VPSB_CMD_OPER_COND_Q, 16'h0, 1'b1, opb[i], 16'h0, 1'b0);
            do_cmd(VPSB_CMD_QUES_COND_Q, 16'h0, 1'b1, qb[i], 16'h0, 1'b0);
        end
        op_f = 8'h00;
        chk1(oper_summary, 1'b1);
        chk1(ques_summary, 1'b1);
        do_cmd(VPSB_CMD_OPER_EVENT_Q, 16'h0, 1'b1, 16'h5f60, 16'h0, 1'b0);
        chk1(oper_summary, 1'b0);
        do_cmd(VPSB_CMD_OPER_EVENT_Q, 16'h0, 1'b1, 16'h0000, 16'h0, 1'b0);
        do_cmd(VPSB_CMD_QUES_EVENT_Q, 16'h0, 1'b1, 16'h3000, 16'h0, 1'b0);
        chk1(ques_summary, 1'b0);
        do_cmd(VPSB_CMD_QUES_EVENT_Q, 16'h0, 1'b1, 16'h0000, 16'h0, 1'b0);
        do_cmd(VPSB_CMD_OPER_COND_Q, 16'h0, 1'b1, 16'h0000, 16'h0, 1'b0);
        // pending value and trigger back to back
        i_host.send(VPSB_CMD_TRIG_VOLT, 16'h0123);
        i_host.send(VPSB_CMD_TRIGGER, 16'h0000);
        i_host.quiet();
        @(negedge clock);
        chk16(voltage_setpoint, 16'h0123);
        close_out();
    end
endmodule

bind vpsb_bank vpsb_bank_properties i_props (.clock(clock), .rst_n(rst_n),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_data(cmd_data),
    .upper_soft_voltage_limit(upper_soft_voltage_limit), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_data2(rsp_data2), .err_valid(err_valid), .err_code(err_code),
    .prot_neg_limit(prot_neg_limit), .prot_pos_limit(prot_pos_limit),
    .voltage_setpoint(voltage_setpoint));
